// File: hw/cmpc_map.vh
// Purpose: Constants for the comparator output control block
// Assumes: Included by bare name from hw design files
// Notes:   Register offsets are byte addresses on the plain register port
`ifndef CMPC_MAP_VH
`define CMPC_MAP_VH
`define CMPC_AW              4
`define CMPC_DW              8
`define CMPC_OFS_CTRL_A      4'h0
`define CMPC_OFS_CTRL_B      4'h1
`define CMPC_OFS_MIRROR      4'h2
`define CMPC_OFS_FLAGS       4'h3
// Control A bit positions
`define CMPC_A_SYNC          0
`define CMPC_A_HYS           1
`define CMPC_A_SPEED         2
`define CMPC_A_POL           4
`define CMPC_A_OE            5
`define CMPC_A_OUT           6
`define CMPC_A_EN            7
`define CMPC_A_WMASK         8'hb7
// Control B bit positions
`define CMPC_B_RISE          7
`define CMPC_B_FALL          6
`define CMPC_B_IE            5
`define CMPC_B_WMASK         8'he0
// Reset values
`define CMPC_RST_A           8'h04
`define CMPC_RST_B           8'h00
`define CMPC_FLAG_BIT        0
`endif

// File: hw/cmpc_sync3.v
// Purpose: Three-stage synchroniser for asynchronous inputs
// Assumes: One clock, asynchronous active-low reset
// Notes:   A change counts once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module cmpc_sync3 (
    input  wire clk_i,
    input  wire resetn_i,
    input  wire d_i,
    output reg  q_o
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1  <= 1'b0;
            s2  <= 1'b0;
            s3  <= 1'b0;
            q_o <= 1'b0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q_o <= s3;
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/cmpc_core.v
// Purpose: Digital side of one analog comparator
// Assumes: Instruction cycle is one clk_i cycle; analog and timer clock inputs are asynchronous
// Notes:   Pin value is combinational from the synchronised result, only the internal copy is latched
//
// Function
// R1: Raw result high when plus exceeds minus
// R2: Comparator works only while enabled
// R3: Output shown in status and mirror bits
// R4: Pin driven when output enable, direction, enable
// R5: Output enable overrides port latch, enable aside
// R6: Internal output latched each instruction cycle
// R7: Invert bit flips raw result
// R8: Speed bit resets to one, normal speed
// R9: Hysteresis enable bit switches hysteresis on
// R10: Output offered as gate timer gate source
// R11: Sync captures output on timer clock fall
// R12: Prescaled timer clock used for sync edge
// R13: Timer counts on rising edge, no race
// R14: Software enables sync when gating timer
// R15: Separate rising and falling edge detectors
// R16: Enabled edge sets interrupt flag
// R17: Software sets enables to receive interrupts
// R18: Flag stays set until software clears
// R19: Edge during clear leaves flag set
// R20: Polarity or enable toggle may set flag
// R21: Edge detect compares with previous cycle
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cmpc_map.vh"
module cmpc_core (
    input  wire                   clk_i,
    input  wire                   resetn_i,
    input  wire [`CMPC_AW-1:0]    addr_i,
    input  wire [`CMPC_DW-1:0]    wdata_i,
    input  wire                   wr_i,
    input  wire                   rd_i,
    output reg  [`CMPC_DW-1:0]    rdata_o,
    input  wire                   analog_cmp_i,
    input  wire                   pin_direction_bit_i,
    input  wire                   port_latch_i,
    input  wire                   timer_clk_i,
    input  wire                   timer_prescaled_clk_i,
    input  wire                   timer_prescale_on_i,
    output wire                   pin_o,
    output wire                   pin_oe_o,
    output wire                   analog_enable_o,
    output wire                   speed_normal_o,
    output wire                   hysteresis_enable_o,
    output reg                    gate_source_o,
    output wire                   comparator_irq_flag_o,
    output wire                   comparator_irq_enable_o
);
    reg  [`CMPC_DW-1:0] ctrl_a;
    reg  [`CMPC_DW-1:0] ctrl_b;
    reg                 irq_flag;
    reg                 out_latched;
    reg                 out_prev;
    reg                 tclk_prev;
    wire                raw_sync;
    wire                tclk_sync;
    wire                tpre_sync;
    wire                comparator_enable_bit;
    wire                output_invert_bit;
    wire                pin_output_enable_bit;
    wire                timer_sync_enable_bit;
    wire                live_out;
    wire                tclk_sel;
    wire                tclk_fall;
    wire                rise_evt;
    wire                fall_evt;
    wire                set_flag;
    wire                clr_flag;

    cmpc_sync3 u_sync_cmp (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (analog_cmp_i),
        .q_o      (raw_sync)
    );
    cmpc_sync3 u_sync_tclk (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (timer_clk_i),
        .q_o      (tclk_sync)
    );
    cmpc_sync3 u_sync_tpre (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (timer_prescaled_clk_i),
        .q_o      (tpre_sync)
    );

    assign comparator_enable_bit = ctrl_a[`CMPC_A_EN];
    assign output_invert_bit     = ctrl_a[`CMPC_A_POL];
    assign pin_output_enable_bit = ctrl_a[`CMPC_A_OE];
    assign timer_sync_enable_bit = ctrl_a[`CMPC_A_SYNC];

    // Disabled comparator reads low before inversion, so toggling enable or invert makes edges
    assign live_out = (raw_sync & comparator_enable_bit) ^ output_invert_bit; // R1 R2 R7 R20
    assign analog_enable_o     = comparator_enable_bit; // R2
    assign speed_normal_o      = ctrl_a[`CMPC_A_SPEED]; // R8
    assign hysteresis_enable_o = ctrl_a[`CMPC_A_HYS]; // R9

    // Pin value unlatched; direction bit low means output
    assign pin_oe_o = pin_output_enable_bit & ~pin_direction_bit_i & comparator_enable_bit; // R4
    assign pin_o    = pin_output_enable_bit ? live_out : port_latch_i; // R5 R6

    assign tclk_sel  = timer_prescale_on_i ? tpre_sync : tclk_sync; // R12
    assign tclk_fall = tclk_prev & ~tclk_sel; // R11 R13

    assign rise_evt = out_latched & ~out_prev; // R15 R21
    assign fall_evt = ~out_latched & out_prev; // R15 R21
    assign set_flag = (rise_evt & ctrl_b[`CMPC_B_RISE]) | (fall_evt & ctrl_b[`CMPC_B_FALL]); // R16
    assign clr_flag = wr_i && (addr_i == `CMPC_OFS_FLAGS) && !wdata_i[`CMPC_FLAG_BIT];

    assign comparator_irq_flag_o   = irq_flag;
    assign comparator_irq_enable_o = ctrl_b[`CMPC_B_IE]; // R17

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_a <= `CMPC_RST_A; // R8
            ctrl_b <= `CMPC_RST_B;
        end else if (wr_i) begin
            if (addr_i == `CMPC_OFS_CTRL_A) begin
                ctrl_a <= wdata_i & `CMPC_A_WMASK;
            end
            if (addr_i == `CMPC_OFS_CTRL_B) begin
                ctrl_b <= wdata_i & `CMPC_B_WMASK;
            end
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_latched <= 1'b0;
            out_prev    <= 1'b0;
            tclk_prev   <= 1'b0;
        end else begin
            out_latched <= live_out; // R6
            out_prev    <= out_latched; // R21
            tclk_prev   <= tclk_sel;
        end
    end

    // Gate source follows output directly, or only on timer clock fall when sync is set
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gate_source_o <= 1'b0;
        end else if (!timer_sync_enable_bit || tclk_fall) begin
            gate_source_o <= live_out; // R10 R11 R14
        end
    end

    // Set beats clear so no edge is lost
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_flag <= 1'b0;
        end else if (set_flag) begin
            irq_flag <= 1'b1; // R16 R19
        end else if (clr_flag) begin
            irq_flag <= 1'b0; // R18
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `CMPC_OFS_CTRL_A: begin
                    rdata_o <= {ctrl_a[`CMPC_A_EN], out_latched, ctrl_a[`CMPC_A_OE:0]}; // R3
                end
                `CMPC_OFS_CTRL_B: begin
                    rdata_o <= ctrl_b;
                end
                `CMPC_OFS_MIRROR: begin
                    rdata_o <= {7'h00, out_latched}; // R3
                end
                `CMPC_OFS_FLAGS: begin
                    rdata_o <= {7'h00, irq_flag};
                end
                default: begin
                    rdata_o <= 8'h00;
                end
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// File: tb/cmpc_chk.sv
// Purpose: Port assertions for cmpc_core
// Assumes: One clock domain
// Notes:   Register bits are judged through their control outputs
`timescale 1ns/100ps
`default_nettype none
module cmpc_chk (
    input wire logic       clk_i,
    input wire logic       resetn_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       pin_direction_bit_i,
    input wire logic       pin_oe_o,
    input wire logic       analog_enable_o,
    input wire logic       speed_normal_o,
    input wire logic       hysteresis_enable_o,
    input wire logic       comparator_irq_flag_o
);
    wire clr_f = wr_i && addr_i == 4'h3 && !wdata_i[0];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence wr_a; wr_i && addr_i == 4'h0; endsequence
    sequence rd_a; rd_i && addr_i == 4'h0; endsequence
    AST_PIN_OE: assert property (pin_oe_o |-> analog_enable_o && !pin_direction_bit_i)
        else $error("pin driven while not allowed");
    AST_EN: assert property (wr_a |=> analog_enable_o == $past(wdata_i[7]))
        else $error("enable bit not written");
    AST_SPEED: assert property (wr_a |=> speed_normal_o == $past(wdata_i[2]))
        else $error("speed bit not written");
    AST_HYS: assert property (wr_a |=> hysteresis_enable_o == $past(wdata_i[1]))
        else $error("hysteresis bit not written");
    AST_RD_EN: assert property (rd_a |=> rdata_o[7] == $past(analog_enable_o))
        else $error("status read differs from enable");
    AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read slot");
    AST_RD_UNMAP: assert property (rd_i && addr_i > 4'h3 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_FLAG_HOLD: assert property (comparator_irq_flag_o && !clr_f |=> comparator_irq_flag_o)
        else $error("flag cleared by hardware");
endmodule
bind cmpc_core cmpc_chk u_chk (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .pin_direction_bit_i, .pin_oe_o, .analog_enable_o, .speed_normal_o,
    .hysteresis_enable_o, .comparator_irq_flag_o);
`default_nettype wire

// File: tb/cmpc_far.sv
// Purpose: Analog pair, gate timer clocks and gated counter
// Assumes: Input voltages arrive as codes from the bench
// Notes:   Timer clock runs free, unrelated to clk_i
`timescale 1ns/100ps
`default_nettype none
module cmpc_far (
    input  wire logic [7:0] vplus_i,
    input  wire logic [7:0] vminus_i,
    input  wire logic       gate_i,
    output var  logic       cmp_o,
    output var  logic       tclk_o,
    output var  logic       tpre_o,
    output var  logic [7:0] count_o
);
    logic [1:0] div = 2'h0;
    logic [7:0] count = 8'h00;
    assign cmp_o = vplus_i > vminus_i;
    assign tpre_o = div[1];
    assign count_o = count;
    initial tclk_o = 1'b0;
    always #17 tclk_o = ~tclk_o;
    always @(posedge tclk_o) begin
        div <= div + 2'h1;
        if (gate_i) count <= count + 8'h01;
    end
endmodule
`default_nettype wire

// File: tb/cmpc_core_bench.sv
// Purpose: Self-checking bench for cmpc_core
// Assumes: 200 MHz clock, reset held 10 cycles
// Notes:   12-cycle settle covers the input synchroniser
`timescale 1ns/100ps
`default_nettype none
module cmpc_core_bench;
    logic       clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, latch = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, vp = 8'h10;
    logic       cmp, tclk, tpre, pin_o, pin_oe_o, gate, flag, irqen;
    logic       dir = 1'b0, pre = 1'b1;
    logic [7:0] cnt, c0;
    logic [9:0] rows [6];
    int         err_total = 0, checked = 0, cyc = 0;
    always #2.5 clk_i = ~clk_i;
    cmpc_core u_dut (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .analog_cmp_i(cmp), .pin_direction_bit_i(dir), .port_latch_i(latch),
        .timer_clk_i(tclk), .timer_prescaled_clk_i(tpre), .timer_prescale_on_i(pre),
        .pin_o, .pin_oe_o, .analog_enable_o(), .speed_normal_o(), .hysteresis_enable_o(),
        .gate_source_o(gate), .comparator_irq_flag_o(flag), .comparator_irq_enable_o(irqen));
    cmpc_far u_far (.vplus_i(vp), .vminus_i(8'h20), .gate_i(gate), .cmp_o(cmp),
        .tclk_o(tclk), .tpre_o(tpre), .count_o(cnt));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp, nm);
    endtask
    task automatic finish_test;
        if (err_total == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        // Rows: ctrl_a, plus above minus, expected output; sync kept on for the gate
        rows = '{10'h297, 10'h294, 10'h2d6, 10'h2d5, 10'h096, 10'h0d7};
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(4'h0, 8'h04, "ctrl_a reset");
        rd(4'h9, 8'h00, "unmapped");
        foreach (rows[i]) begin
            wr(4'h0, rows[i][9:2]);
            vp <= rows[i][1] ? 8'h30 : 8'h10;
            latch <= ~rows[i][0];
            repeat (12) @(posedge clk_i);
            rd(4'h2, {7'h00, rows[i][0]}, "mirror");
            chk({7'h00, pin_o}, {7'h00, rows[i][0]}, "pin");
            chk({7'h00, pin_oe_o}, {7'h00, rows[i][9]}, "pin_oe");
            rd(4'h0, rows[i][9:2] | {1'b0, rows[i][0], 6'h00}, "ctrl_a");
        end
        wr(4'h1, 8'he0);
        rd(4'h1, 8'he0, "ctrl_b");
        chk({7'h00, irqen}, 8'h01, "irq enable");
        wr(4'h3, 8'h00);
        rd(4'h3, 8'h00, "flag clear");
        wr(4'h0, 8'h25);
        repeat (8) @(posedge clk_i);
        rd(4'h3, 8'h01, "flag fall");
        chk({7'h00, flag}, 8'h01, "flag output");
        wr(4'h3, 8'h01);
        repeat (20) @(posedge clk_i);
        rd(4'h3, 8'h01, "flag hold");
        wr(4'h1, 8'h80);
        wr(4'h3, 8'h00);
        wr(4'h0, 8'h35);
        repeat (8) @(posedge clk_i);
        rd(4'h3, 8'h01, "flag rise");
        chk({7'h00, irqen}, 8'h00, "irq enable off");
        wr(4'h3, 8'h00);
        wr(4'h0, 8'h25);
        repeat (8) @(posedge clk_i);
        rd(4'h3, 8'h00, "fall masked");
        // Clear lands in the very cycle that the rising edge is seen
        wr(4'h0, 8'h35);
        wr(4'h3, 8'h00);
        rd(4'h3, 8'h01, "set beats clear");
        wr(4'h0, 8'ha3);
        dir <= 1'b1;
        vp <= 8'h10;
        // Prescaled clock is slow, so allow more than one of its periods
        repeat (48) @(posedge clk_i);
        vp <= 8'h30;
        pre <= 1'b0;
        c0 = cnt;
        #1 chk({7'h00, gate}, 8'h00, "gate sync low");
        repeat (40) @(posedge clk_i);
        #1 chk({7'h00, gate}, 8'h01, "gate sync high");
        chk({7'h00, cnt != c0}, 8'h01, "timer count");
        chk({6'h00, pin_oe_o, pin_o}, 8'h01, "pin direction in");
        wr(4'h0, 8'h82);
        vp <= 8'h10;
        latch <= 1'b0;
        repeat (12) @(posedge clk_i);
        vp <= 8'h30;
        repeat (6) @(posedge clk_i);
        #1 chk({7'h00, gate}, 8'h01, "gate direct");
        chk({7'h00, pin_o}, 8'h00, "pin from latch");
        rd(4'h0, 8'hc2, "ctrl_a speed hys");
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(4'h0, 8'h04, "ctrl_a rereset");
        rd(4'h1, 8'h00, "ctrl_b reset");
        chk({7'h00, flag}, 8'h00, "flag reset");
        finish_test();
    end
endmodule
`default_nettype wire
